/* uadb_top.sv */
// The APB slave port was decided locally.
`timescale 1ns/100ps
// Overview of operation
// - store each received byte, line or ir
// - rx byte valid only while data ready
// - no fifo: overwrite unread byte, flag overrun
// - fifo: data read returns oldest entry
// - rx fifo full: drop new byte, overrun
// - send written bytes on line or ir
// - no fifo: one write clears transmit empty
// - no fifo: later writes replace pending byte
// - fifo: accept sixteen bytes before full
// - write to full tx fifo is dropped
// - low divisor byte is bits 7:0
// - baud is clock over sixteen times divisor
// - zero divisor stops baud and traffic
// - high divisor shares interrupt enable address
module uadb_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serIn,
  output logic serOut,
  input wire logic sirIn,
  output logic sirOutN,
  output logic irq
);
  // ---------------------------------------------------------------
  // state of the whole block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dll; // divisor low
    logic [7:0] divisor_high_byte; // divisor high
    logic [7:0] ier; // interrupt enable byte
    logic [7:0] lcr; // line control
    logic fifoEn; // fifos on
    logic [7:0] rxHold; // single rx byte, fifos off
    logic rxHoldValid; // rxHold unread
    logic [7:0] txHold; // single tx byte, fifos off
    logic txHoldFull; // txHold pending
    logic overrun; // sticky line status
    logic [3:0] istat; // sticky events
    logic [3:0] imask; // event enables
    logic irq; // interrupt output
    logic threPrev; // edge detect of empty
    uadb_pkg::uadb_ser_t txSt; // transmitter state
    logic [3:0] txTick; // ticks into tx bit
    logic [2:0] txBit; // tx data bit index
    logic [7:0] txShift; // tx shifter
    logic serOut; // line output
    logic sirOutN; // ir output, low is a pulse
    uadb_pkg::uadb_ser_t rxSt; // receiver state
    logic [3:0] rxTick; // ticks into rx bit
    logic [2:0] rxBit; // rx data bit index
    logic [7:0] rxShift; // rx shifter
    logic irSeen; // ir pulse seen this bit
    logic [31:0] prdata; // read data
    logic pready; // access done
    logic pslverr; // unmapped address
  } uadb_state_t;
  uadb_state_t s_q, s_d;
  // fifo and baud wiring
  logic baudTick;
  logic rxPush, rxPushReady, rxPop, rxValid, rxFlush;
  logic [7:0] rxData, rxByte;
  logic txPush, txPushReady, txPop, txValid, txFlush;
  logic [7:0] txData;
  // outputs straight from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign serOut = s_q.serOut;
  assign sirOutN = s_q.sirOutN;
  assign irq = s_q.irq;
  // tick counter step, used by both engines
  function automatic logic [3:0] uadb_inc4(input logic [3:0] v);
    uadb_inc4 = v + 4'h1;
  endfunction
  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  // ticks at sixteen per bit; none while divisor is zero
  uadb_baud baud (
    .core_clk(core_clk),
    .rst(rst),
    .divisor({s_q.divisor_high_byte, s_q.dll}),
    .tick(baudTick)
  );
  // receive fifo
  uadb_fifo rxFifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(rxFlush),
    .pushValid(rxPush),
    .pushData(rxByte),
    .pushReady(rxPushReady),
    .popReady(rxPop),
    .popValid(rxValid),
    .popData(rxData)
  );
  // transmit fifo
  uadb_fifo txFifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(txFlush),
    .pushValid(txPush),
    .pushData(pwdata[7:0]),
    .pushReady(txPushReady),
    .popReady(txPop),
    .popValid(txValid),
    .popData(txData)
  );
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // the order of sections matters: hardware sets come after bus
  // clears so an event in the clearing cycle is never lost
  always_comb
  begin
    logic access, dlab, irMode, dataReady, transmit_empty_flag, lineBit, rxLvl;
    logic txAvail;
    logic [7:0] rdByte;
    access = 1'b0;
    dlab = 1'b0;
    irMode = 1'b0;
    dataReady = 1'b0;
    transmit_empty_flag = 1'b0;
    lineBit = 1'b1;
    rxLvl = 1'b1;
    txAvail = 1'b0;
    rdByte = 8'h00;
    s_d = s_q;
    rxPush = 1'b0;
    rxPop = 1'b0;
    rxFlush = 1'b0;
    txPush = 1'b0;
    txPop = 1'b0;
    txFlush = 1'b0;
    rxByte = s_q.rxShift;
    dlab = s_q.lcr[uadb_pkg::LCR_DLAB];
    irMode = s_q.lcr[uadb_pkg::LCR_IR];
    // data ready: valid rx byte waiting
    dataReady = s_q.fifoEn ? rxValid : s_q.rxHoldValid;
    transmit_empty_flag = s_q.fifoEn ? !txValid : !s_q.txHoldFull;
    // ---- transmitter, advances only on a baud tick ----
    txAvail = s_q.fifoEn ? txValid : s_q.txHoldFull;
    if (baudTick)
    begin
      s_d.txTick = uadb_inc4(s_q.txTick);
      case (s_q.txSt)
        uadb_pkg::SER_IDLE:
        begin
          s_d.txTick = '0;
          if (txAvail)
          begin
            s_d.txSt = uadb_pkg::SER_START;
            s_d.txShift = s_q.fifoEn ? txData : s_q.txHold;
            txPop = s_q.fifoEn;
            s_d.txHoldFull = 1'b0;
          end
        end
        uadb_pkg::SER_START:
          if (s_q.txTick == uadb_pkg::TICK_LAST)
          begin
            s_d.txSt = uadb_pkg::SER_DATA;
            s_d.txBit = '0;
          end
        uadb_pkg::SER_DATA:
          if (s_q.txTick == uadb_pkg::TICK_LAST)
          begin
            // lsb first
            s_d.txShift = {1'b0, s_q.txShift[7:1]};
            s_d.txBit = s_q.txBit + 3'h1;
            if (s_q.txBit == uadb_pkg::BIT_LAST)
              s_d.txSt = uadb_pkg::SER_STOP;
          end
        uadb_pkg::SER_STOP:
          if (s_q.txTick == uadb_pkg::TICK_LAST)
            s_d.txSt = uadb_pkg::SER_IDLE;
        default:
          s_d.txSt = uadb_pkg::SER_IDLE;
      endcase
    end
    // line level of the next state; ir sends a short low pulse per zero
    case (s_d.txSt)
      uadb_pkg::SER_START: lineBit = 1'b0;
      uadb_pkg::SER_DATA: lineBit = s_d.txShift[0];
      default: lineBit = 1'b1;
    endcase
    s_d.serOut = irMode ? 1'b1 : lineBit;
    s_d.sirOutN = !(irMode && !lineBit && s_d.txTick < uadb_pkg::IR_PULSE);
    // ---- register bus: one wait state, answer from flops ----
    access = psel && penable && !s_q.pready;
    s_d.pready = access;
    s_d.pslverr = 1'b0;
    if (access)
    begin
      rdByte = 8'h00;
      case (paddr)
        uadb_pkg::ADDR_DATA:
          if (dlab)
          begin
            // divisor low byte
            rdByte = s_q.dll;
            if (pwrite)
              s_d.dll = pwdata[7:0];
          end
          else if (!pwrite)
          begin
            // read pops the fifo head or frees the holding byte
            rdByte = s_q.fifoEn ? rxData : s_q.rxHold;
            rxPop = s_q.fifoEn;
            s_d.rxHoldValid = 1'b0;
          end
          else if (s_q.fifoEn)
          begin
            txPush = 1'b1;
            // full fifo: byte lost, contents untouched
            if (!txPushReady && !txPop)
              s_d.istat[uadb_pkg::IRQ_DROP] = 1'b1;
          end
          else
          begin
            // a second write simply replaces the pending byte
            s_d.txHold = pwdata[7:0];
            s_d.txHoldFull = 1'b1;
          end
        uadb_pkg::ADDR_DLH:
        begin
          // divisor high and interrupt enables share this word
          rdByte = dlab ? s_q.divisor_high_byte : s_q.ier;
          if (pwrite && dlab)
            s_d.divisor_high_byte = pwdata[7:0];
          else if (pwrite)
            s_d.ier = pwdata[7:0];
        end
        uadb_pkg::ADDR_FCR:
        begin
          rdByte = {7'h00, s_q.fifoEn};
          if (pwrite)
          begin
            s_d.fifoEn = pwdata[uadb_pkg::FCR_EN];
            // switching mode empties both fifos to avoid stale bytes
            rxFlush = pwdata[uadb_pkg::FCR_RXRST] || (pwdata[uadb_pkg::FCR_EN] != s_q.fifoEn);
            txFlush = pwdata[uadb_pkg::FCR_TXRST] || (pwdata[uadb_pkg::FCR_EN] != s_q.fifoEn);
          end
        end
        uadb_pkg::ADDR_LCR:
        begin
          rdByte = s_q.lcr;
          if (pwrite)
            s_d.lcr = pwdata[7:0];
        end
        uadb_pkg::ADDR_LSR:
        begin
          rdByte[uadb_pkg::LSR_DR] = dataReady;
          rdByte[uadb_pkg::LSR_OE] = s_q.overrun;
          rdByte[uadb_pkg::LSR_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag;
          rdByte[uadb_pkg::LSR_TEMT] = transmit_empty_flag && (s_q.txSt == uadb_pkg::SER_IDLE);
          // reading line status clears overrun
          if (!pwrite)
            s_d.overrun = 1'b0;
        end
        uadb_pkg::ADDR_ISTAT:
        begin
          rdByte = {4'h0, s_q.istat};
          // write one to clear
          if (pwrite)
            s_d.istat = s_d.istat & ~pwdata[3:0];
        end
        uadb_pkg::ADDR_IMASK:
        begin
          rdByte = {4'h0, s_q.imask};
          if (pwrite)
            s_d.imask = pwdata[3:0];
        end
        default:
          s_d.pslverr = 1'b1;
      endcase
      // upper bits always zero
      s_d.prdata = {24'h000000, rdByte};
    end
    // ---- receiver, advances only on a baud tick ----
    // ir: a pulse anywhere before the sample point means a zero
    rxLvl = irMode ? !(s_q.irSeen || sirIn) : serIn;
    s_d.irSeen = irMode && (s_q.irSeen || sirIn);
    if (baudTick)
    begin
      s_d.rxTick = uadb_inc4(s_q.rxTick);
      case (s_q.rxSt)
        uadb_pkg::SER_IDLE:
        begin
          s_d.rxTick = '0;
          if (!rxLvl)
            s_d.rxSt = uadb_pkg::SER_START;
        end
        uadb_pkg::SER_START:
          if (s_q.rxTick == uadb_pkg::TICK_MID)
          begin
            // a glitch shorter than half a bit is not a start
            s_d.rxSt = rxLvl ? uadb_pkg::SER_IDLE : uadb_pkg::SER_DATA;
            s_d.rxTick = '0;
            s_d.rxBit = '0;
            s_d.irSeen = 1'b0;
          end
        uadb_pkg::SER_DATA:
          if (s_q.rxTick == uadb_pkg::TICK_LAST)
          begin
            s_d.rxShift = {rxLvl, s_q.rxShift[7:1]};
            s_d.rxBit = s_q.rxBit + 3'h1;
            s_d.irSeen = 1'b0;
            if (s_q.rxBit == uadb_pkg::BIT_LAST)
              s_d.rxSt = uadb_pkg::SER_STOP;
          end
        uadb_pkg::SER_STOP:
          if (s_q.rxTick == uadb_pkg::TICK_LAST)
          begin
            // stop bit is not checked; byte delivered here
            s_d.rxSt = uadb_pkg::SER_IDLE;
            s_d.irSeen = 1'b0;
            s_d.istat[uadb_pkg::IRQ_RX] = 1'b1;
            if (s_q.fifoEn)
            begin
              // full fifo keeps its contents, new byte dropped
              rxPush = rxPushReady;
              if (!rxPushReady || rxPop)
              begin
                // a pop in this cycle frees room: push still allowed
                rxPush = rxPushReady || rxPop;
              end
              if (!rxPushReady && !rxPop)
              begin
                s_d.overrun = 1'b1;
                s_d.istat[uadb_pkg::IRQ_OVR] = 1'b1;
              end
            end
            else
            begin
              // unread byte overwritten
              if (s_d.rxHoldValid)
              begin
                s_d.overrun = 1'b1;
                s_d.istat[uadb_pkg::IRQ_OVR] = 1'b1;
              end
              s_d.rxHold = s_q.rxShift;
              s_d.rxHoldValid = 1'b1;
            end
          end
        default:
          s_d.rxSt = uadb_pkg::SER_IDLE;
      endcase
    end
    // ---- events and interrupt line ----
    s_d.threPrev = transmit_empty_flag;
    if (transmit_empty_flag && !s_q.threPrev)
      s_d.istat[uadb_pkg::IRQ_TRANSMIT_EMPTY_FLAG] = 1'b1;
    s_d.irq = |(s_d.istat & s_d.imask);
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.dll <= uadb_pkg::BYTE_RST;
      s_q.divisor_high_byte <= uadb_pkg::BYTE_RST;
      s_q.istat <= uadb_pkg::IRQ_RST;
      s_q.txSt <= uadb_pkg::SER_IDLE;
      s_q.rxSt <= uadb_pkg::SER_IDLE;
      s_q.serOut <= 1'b1;
      s_q.sirOutN <= 1'b1;
      s_q.threPrev <= 1'b1;
    end
    else
      s_q <= s_d;
  end
endmodule

/* uadb_pkg.sv */
package uadb_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] ADDR_DATA = 32'h5000_1000; // rx / tx / divisor low
  localparam logic [31:0] ADDR_DLH = 32'h5000_1004; // divisor high / int enable
  localparam logic [31:0] ADDR_FCR = 32'h5000_1008; // fifo control
  localparam logic [31:0] ADDR_LCR = 32'h5000_100c; // line control
  localparam logic [31:0] ADDR_LSR = 32'h5000_1014; // line status
  localparam logic [31:0] ADDR_ISTAT = 32'h5000_1040; // sticky events
  localparam logic [31:0] ADDR_IMASK = 32'h5000_1044; // event mask
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LCR_DLAB = 7; // divisor access
  localparam int LCR_IR = 6; // infrared mode
  localparam int FCR_EN = 0; // fifos enabled
  localparam int FCR_RXRST = 1; // flush rx fifo
  localparam int FCR_TXRST = 2; // flush tx fifo
  localparam int LSR_DR = 0; // data ready
  localparam int LSR_OE = 1; // overrun
  localparam int LSR_TRANSMIT_EMPTY_FLAG = 5; // transmit empty
  localparam int LSR_TEMT = 6; // shifter idle too
  localparam int IRQ_RX = 0; // character received
  localparam int IRQ_OVR = 1; // overrun
  localparam int IRQ_TRANSMIT_EMPTY_FLAG = 2; // transmit empty rose
  localparam int IRQ_DROP = 3; // tx write lost
  localparam int IRQ_W = 4;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [3:0] TICK_LAST = 4'hf; // sixteen ticks a bit
  localparam logic [3:0] TICK_MID = 4'h7; // centre of start bit
  localparam logic [3:0] IR_PULSE = 4'h3; // ir pulse, 3/16 bit
  localparam logic [2:0] BIT_LAST = 3'h7; // eight data bits
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b11,
    SER_STOP = 2'b10
  } uadb_ser_t;
endpackage

/* uadb_fifo.sv */
`timescale 1ns/100ps
// byte fifo, one entry written and one read per cycle at most
module uadb_fifo (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic pushValid,
  input wire logic [7:0] pushData,
  output logic pushReady,
  input wire logic popReady,
  output logic popValid,
  output logic [7:0] popData
);
  typedef struct packed {
    logic [uadb_pkg::FIFO_DEPTH-1:0][7:0] mem; // storage
    logic [uadb_pkg::FIFO_AW-1:0] wp; // write pointer
    logic [uadb_pkg::FIFO_AW-1:0] rp; // read pointer
    logic [uadb_pkg::FIFO_AW:0] cnt; // fill level
  } uadb_fifo_t;
  uadb_fifo_t s_q, s_d;
  // full and empty come straight from the count, no pointer tricks
  assign pushReady = (s_q.cnt != 5'(uadb_pkg::FIFO_DEPTH));
  assign popValid = (s_q.cnt != '0);
  assign popData = s_q.mem[s_q.rp];
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic doPush, doPop;
    doPop = popReady && popValid;
    // a pop in the same cycle frees the slot a full fifo needs, so no byte is lost silently
    doPush = pushValid && (pushReady || doPop);
    s_d = s_q;
    if (doPush)
    begin
      s_d.mem[s_q.wp] = pushData;
      s_d.wp = s_q.wp + 4'h1;
    end
    if (doPop)
      s_d.rp = s_q.rp + 4'h1;
    s_d.cnt = s_q.cnt + 5'(doPush) - 5'(doPop);
    // flush wins over everything in the same cycle
    if (flush)
    begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end
  end
  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

/* uadb_baud.sv */
`timescale 1ns/100ps
// sixteen-times oversampling tick: one pulse every divisor cycles
module uadb_baud (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt; // cycles into this tick
    logic tick; // registered pulse
  } uadb_baud_t;
  uadb_baud_t s_q, s_d;
  assign tick = s_q.tick;
  // ---------------------------------------------------------------
  // divider; >= so a smaller divisor written mid-count wraps at once
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (divisor == 16'h0000)
      s_d.cnt = '0;
    else if (s_q.cnt >= divisor - 16'h0001)
    begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.cnt = s_q.cnt + 16'h0001;
  end
  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

/* uadb_checker_assertions.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// port checks for the register bus, the line outputs and the interrupt
// ------------------------------------------------------------
module uadb_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serOut,
  input wire logic sirOutN,
  input wire logic irq
);
  logic wrSeen_q; // some data write accepted since reset
  logic [3:0] mask_q; // shadow of the event mask
  logic take; // first access cycle of a transfer
  assign take = psel && penable && !pready;
  // shadows follow accepted writes only, so a refused one leaves them alone
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrSeen_q <= 1'b0;
      mask_q <= 4'h0;
    end
    else if (take && pwrite)
    begin
      if (paddr == uadb_pkg::ADDR_DATA)
        wrSeen_q <= 1'b1;
      if (paddr == uadb_pkg::ADDR_IMASK)
        mask_q <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_wait_state: assert property (take |=> pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access");
  a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access with data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_data_hold: assert property (!pready |-> $stable(prdata))
    else $error("read data moved between accesses");
  a_line_quiet: assert property (!wrSeen_q |-> serOut && sirOutN)
    else $error("line moved before any byte");
  a_start_width: assert property ($fell(serOut) |-> (!serOut) [*8])
    else $error("start bit too short");
  a_one_output: assert property ($fell(serOut) |-> sirOutN)
    else $error("both outputs active");
  a_mask_quiet: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
    else $error("interrupt while all masked");
endmodule
bind uadb_top uadb_checker chkU (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serOut(serOut), .sirOutN(sirOutN), .irq(irq));

/* uadb_partner.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// remote transceiver: sends frames, collects line frames
// ------------------------------------------------------------
module uadb_partner (
  input wire logic core_clk,
  input wire logic serOut,
  output logic serIn,
  output logic sirIn
);
  int bitCycles = 32; // core cycles per bit, sixteen times the divisor of 2 the bench writes
  logic [7:0] rxQ[$]; // bytes seen on the line
  logic [7:0] v; // byte being collected
  logic [9:0] fr; // frame being sent
  initial
  begin
    serIn = 1'b1; // line idles high
    sirIn = 1'b0; // no light, no pulse
  end
  // one 8n1 frame, lsb first; ir sends a short high pulse per zero bit
  task automatic send(input logic [7:0] b, input logic ir);
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      if (ir)
      begin
        sirIn <= !fr[i];
        repeat (bitCycles * 3 / 16) @(posedge core_clk);
        sirIn <= 1'b0;
        repeat (bitCycles - bitCycles * 3 / 16 - 1) @(posedge core_clk);
      end
      else
      begin
        serIn <= fr[i];
        repeat (bitCycles - 1) @(posedge core_clk);
      end
    end
    // one idle bit so the byte is delivered before the caller looks
    repeat (bitCycles) @(posedge core_clk);
  endtask
  // sample at bit centres, so a wrong bit time shows as wrong data
  always
  begin
    @(posedge core_clk);
    if (serOut === 1'b0)
    begin
      repeat (bitCycles / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitCycles) @(posedge core_clk);
        v[i] = serOut;
      end
      rxQ.push_back(v);
      repeat (bitCycles) @(posedge core_clk);
    end
  end
endmodule

/* test_uart_data_buffer_baud_divisor.sv */
`timescale 1ns/100ps
module test_uart_data_buffer_baud_divisor;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic serIn, serOut, sirIn, sirOutN, irq, e;
  logic [31:0] paddr, pwdata, prdata, rd;
  int failures, tests_run, cycles, irFalls, serFalls;
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] x; logic err;} uadb_row_t;
  // register rows: write, address, data, expected read, expected refusal
  uadb_row_t rows[9] = '{
    '{1'b1, uadb_pkg::ADDR_LCR, 32'h80, 32'h0, 1'b0},
    '{1'b1, uadb_pkg::ADDR_DATA, 32'hab02, 32'h0, 1'b0},
    '{1'b0, uadb_pkg::ADDR_DATA, 32'h0, 32'h02, 1'b0},
    '{1'b1, uadb_pkg::ADDR_DLH, 32'h5a, 32'h0, 1'b0},
    '{1'b0, uadb_pkg::ADDR_DLH, 32'h0, 32'h5a, 1'b0},
    '{1'b1, uadb_pkg::ADDR_DLH, 32'h00, 32'h0, 1'b0},
    '{1'b0, 32'h5000_1010, 32'h0, 32'h0, 1'b1},
    '{1'b1, uadb_pkg::ADDR_LCR, 32'h00, 32'h0, 1'b0},
    '{1'b0, uadb_pkg::ADDR_LSR, 32'h0, 32'h60, 1'b0}};
  uadb_top dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serIn(serIn), .serOut(serOut), .sirIn(sirIn), .sirOutN(sirOutN),
    .irq(irq));
  uadb_partner partnerU (.core_clk(core_clk), .serOut(serOut), .serIn(serIn), .sirIn(sirIn));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // edge counts on both outputs; cycle ceiling cuts a hang short
  always @(negedge sirOutN) irFalls++;
  always @(negedge serOut) serFalls++;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // apb: setup, access, hold until ready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, rd);
  endtask
  task automatic waitq(input int n);
    while (partnerU.rxQ.size() < n)
      @(posedge core_clk);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    repeat (20) @(posedge core_clk);
    chk("reset pins", 32'hc, {28'h0, serOut, sirOutN, irq, pready});
    chk("reset data", 32'h0, prdata);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("row read", rows[i].x, rd);
      chk("row refusal", {31'h0, rows[i].err}, {31'h0, e});
    end
    $display("test registers done");
    rdc("empty before", uadb_pkg::ADDR_LSR, 32'h60);
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'h55);
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'h11);
    rdc("empty flag", uadb_pkg::ADDR_LSR, 32'h00);
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'h22);
    waitq(2);
    chk("tx first", 32'h55, {24'h0, partnerU.rxQ.pop_front()});
    chk("tx replaced", 32'h22, {24'h0, partnerU.rxQ.pop_front()});
    $display("test transmit done");
    partnerU.send(8'h3c, 1'b0);
    rdc("ready flag", uadb_pkg::ADDR_LSR, 32'h61);
    partnerU.send(8'h5a, 1'b0);
    rdc("overrun", uadb_pkg::ADDR_LSR, 32'h63);
    rdc("overwritten", uadb_pkg::ADDR_DATA, 32'h5a);
    rdc("drained", uadb_pkg::ADDR_LSR, 32'h60);
    apb(1'b1, uadb_pkg::ADDR_IMASK, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, uadb_pkg::ADDR_IMASK, 32'h0);
    @(posedge core_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, uadb_pkg::ADDR_ISTAT, 32'hf);
    apb(1'b1, uadb_pkg::ADDR_IMASK, 32'h1);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test receive done");
    apb(1'b1, uadb_pkg::ADDR_FCR, 32'h1);
    for (int i = 0; i < 18; i++)
      apb(1'b1, uadb_pkg::ADDR_DATA, i);
    waitq(17);
    for (int i = 0; i < 17; i++)
      chk("tx fifo", i, {24'h0, partnerU.rxQ.pop_front()});
    repeat (640) @(posedge core_clk);
    chk("tx lost", 32'h0, partnerU.rxQ.size());
    apb(1'b0, uadb_pkg::ADDR_ISTAT, 32'h0);
    chk("lost event", 32'h8, rd & 32'h8);
    for (int i = 0; i < 17; i++)
      partnerU.send(8'h80 + i, 1'b0);
    rdc("rx full", uadb_pkg::ADDR_LSR, 32'h63);
    for (int i = 0; i < 16; i++)
      rdc("rx order", uadb_pkg::ADDR_DATA, 32'h80 + i);
    rdc("rx empty", uadb_pkg::ADDR_LSR, 32'h60);
    $display("test fifo done");
    apb(1'b1, uadb_pkg::ADDR_LCR, 32'h40);
    partnerU.send(8'h0f, 1'b1);
    rdc("ir rx", uadb_pkg::ADDR_DATA, 32'h0f);
    {irFalls, serFalls} = '0;
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'hf0);
    repeat (400) @(posedge core_clk);
    chk("ir pulses", 32'h5, irFalls);
    chk("line still", 32'h0, serFalls);
    $display("test infrared done");
    apb(1'b1, uadb_pkg::ADDR_LCR, 32'h80);
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'h0);
    rdc("divisor low", uadb_pkg::ADDR_DATA, 32'h0);
    apb(1'b1, uadb_pkg::ADDR_LCR, 32'h0);
    serFalls = 0;
    apb(1'b1, uadb_pkg::ADDR_DATA, 32'h00);
    repeat (300) @(posedge core_clk);
    chk("stopped", 32'h0, serFalls);
    $display("test zero divisor done");
    // mid-run reset with a byte stuck in the tx fifo: status must come back clean
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rdc("reset status", uadb_pkg::ADDR_LSR, 32'h60);
    rdc("reset rx byte", uadb_pkg::ADDR_DATA, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule
